// ### spi_pkg.sv
// Purpose: shared constants and types for the serial status and data port
// Assumes: classic wishbone register access, 8-bit registers in low bits
// Notes:   registers occupy one aligned word each
package spi_pkg;
    // =========================================================
    // register map (word index; byte address is four times it)
    localparam logic [7:0] STATUS_IDX  = 8'h_00f4;
    localparam logic [7:0] DATA_IDX    = 8'h_00f5;
    localparam logic [7:0] CONTROL_IDX = 8'h_00f6;
    localparam logic [7:0] MASK_IDX    = 8'h_00f7;
    localparam logic [7:0] EVENT_IDX   = 8'h_00f8;
    // =========================================================
    // status fields
    localparam int DONE_BIT     = 7;
    localparam int CLASH_BIT    = 6;
    localparam int OVERRUN_BIT  = 5;
    localparam int CONFLICT_BIT = 4;
    localparam int DETOFF_BIT   = 3;
    localparam int TXFULL_BIT   = 2;
    // control fields
    localparam int ROLE_BIT     = 0;
    localparam int SELOE_BIT    = 1;
    localparam int IRQEN_BIT    = 2;
    localparam int GIRQEN_BIT   = 3;
    // =========================================================
    // reset values and timing
    localparam logic [7:0] STATUS_RST  = 8'h_0000;
    localparam logic [7:0] DATA_RST    = 8'h_0000;
    localparam logic [7:0] CONTROL_RST = 8'h_0000;
    localparam logic [7:0] MASK_RST    = 8'h_0000;
    localparam int         CLK_HZ      = 25_000_000;
    localparam int         HALF_NS     = 160;
    localparam int         HALF_CYC    = (HALF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [3:0] HALF_CNT    = 4'(HALF_CYC);
    localparam logic [2:0] BIT_LAST    = 3'h_7;
    // =========================================================
    // shifter state
    typedef enum logic [1:0] {IDLE, LEAD, TRAIL} shift_state_t;
endpackage

// ### shift_if.sv
`timescale 1ns/100ps
// Purpose: carries load/done between register front end and shifter
// Assumes: single clock domain
// Notes:   load is a one-cycle pulse
interface shift_if;
    logic       load;
    logic [7:0] tx_byte;
    logic       busy;
    logic       done;
    logic [7:0] rx_byte;
    modport ctrl (output load, output tx_byte, input busy, input done, input rx_byte);
    modport core (input load, input tx_byte, output busy, output done, output rx_byte);
endinterface

// ### spi_shifter.sv
`timescale 1ns/100ps
// Purpose: byte shifter, master clock generation and slave clock sampling
// Assumes: mode 0, msb first; pins already synchronised
// Notes:   master toggles link clock every HALF_CNT cycles
module spi_shifter
    import spi_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic ce,
    // mode
    input  wire logic is_master,
    // synchronised pins
    input  wire logic sck_s,
    input  wire logic sel_s_n,
    input  wire logic din_s,
    // pin drives
    output logic      sck_out,
    output logic      dout,
    // front end
    shift_if.core     sh
);
    typedef struct packed {
        shift_state_t st;
        logic [7:0]   sh_r;
        logic [2:0]   bits;
        logic [3:0]   cnt;
        logic         sck;
        logic         sck_d;
        logic         smp;
        logic         done;
        logic [7:0]   rx;
    } core_t;
    core_t s_r, s_nxt;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        s_nxt.sck_d = sck_s;
        if (sh.load && s_r.st == IDLE) begin
            s_nxt.sh_r = sh.tx_byte;
            s_nxt.bits = 3'h_0;
            s_nxt.cnt  = 4'h_0;
            if (is_master) begin
                s_nxt.st = LEAD;
            end
        end else if (is_master) begin
            if (s_r.st != IDLE) begin
                s_nxt.cnt = s_r.cnt + 4'h_1;
                if (s_r.cnt == HALF_CNT - 4'h_1) begin
                    s_nxt.cnt = 4'h_0;
                    if (s_r.st == LEAD) begin
                        // sample on the rise, keep data out steady
                        s_nxt.sck  = 1'b1;
                        s_nxt.smp  = din_s;
                        s_nxt.st   = TRAIL;
                    end else begin
                        // shift out on the fall
                        s_nxt.sck  = 1'b0;
                        s_nxt.sh_r = {s_r.sh_r[6:0], s_r.smp};
                        s_nxt.bits = s_r.bits + 3'h_1;
                        s_nxt.st   = LEAD;
                        if (s_r.bits == BIT_LAST) begin
                            s_nxt.st   = IDLE;
                            s_nxt.done = 1'b1;
                            s_nxt.rx   = {s_r.sh_r[6:0], s_r.smp};
                        end
                    end
                end
            end
        end else begin
            s_nxt.st  = IDLE;
            s_nxt.sck = 1'b0;
            if (sel_s_n) begin
                s_nxt.bits = 3'h_0;
            end else if (sck_s && !s_r.sck_d) begin
                // sample on the rise
                s_nxt.smp  = din_s;
                s_nxt.bits = s_r.bits + 3'h_1;
                if (s_r.bits == BIT_LAST) begin
                    s_nxt.done = 1'b1;
                    s_nxt.rx   = {s_r.sh_r[6:0], din_s};
                end
            end else if (!sck_s && s_r.sck_d) begin
                // shift out on the fall
                s_nxt.sh_r = {s_r.sh_r[6:0], s_r.smp};
            end
        end
        if (!ce) begin
            s_nxt = s_r;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_r <= '{IDLE, 8'h_0000, 3'h_0, 4'h_0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h_0000};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sck_out  = s_r.sck;
    assign dout     = s_r.sh_r[7];
    assign sh.busy  = (s_r.st != IDLE);
    assign sh.done  = s_r.done;
    assign sh.rx_byte = s_r.rx;
endmodule

// ### spi_port.sv
// The Wishbone slave port was decided locally.
`timescale 1ns/100ps
// Purpose: status flags, data port, interrupt and select pin handling
// Assumes: classic wishbone slave, one aligned word per register
// Notes:   link pins pass two flip-flops before use
module spi_port
    import spi_pkg::*;
(
    // system
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        ce,
    // wishbone
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // link pins
    input  wire logic        sck_i,
    output logic             sck_o,
    output logic             sck_oe_n,
    input  wire logic        mosi_i,
    output logic             mosi_o,
    output logic             mosi_oe_n,
    input  wire logic        miso_i,
    output logic             miso_o,
    output logic             miso_oe_n,
    input  wire logic        sel_n_i,
    output logic             sel_n_o,
    output logic             sel_oe_n,
    // interrupt
    output logic             irq
);
    typedef struct packed {
        logic [1:0] sck_sy;
        logic [1:0] mosi_sy;
        logic [1:0] miso_sy;
        logic [1:0] sel_sy;
        logic       done;
        logic       clash;
        logic       overrun;
        logic       conflict;
        logic       det_off;
        logic       tx_full;
        logic [7:0] rbuf;
        logic [7:0] ctrl;
        logic [7:0] mask;
        logic       ack;
        logic [7:0] rdat;
    } port_t;
    port_t p_r, p_nxt;

    shift_if sh ();

    logic master;
    logic detect_on;
    logic sel_low;
    logic wb_req;
    logic [7:0] events;

    // =========================================================
    // helpers
    function automatic logic hit(input logic [31:0] adr, input logic [7:0] idx);
        hit = (adr[31:2] == {22'h_0000_00, idx}) && (adr[1:0] == 2'b00);
    endfunction

    assign master    = p_r.ctrl[ROLE_BIT];
    assign detect_on = master && !p_r.det_off;
    assign sel_low   = !p_r.sel_sy[1];
    assign wb_req    = wb_cyc_i && wb_stb_i && !p_r.ack;
    assign events    = {p_r.done, 1'b0, p_r.overrun, p_r.conflict, 4'h_0};

    // =========================================================
    // register and flag logic
    always_comb begin
        p_nxt         = p_r;
        p_nxt.sck_sy  = {p_r.sck_sy[0], sck_i};
        p_nxt.mosi_sy = {p_r.mosi_sy[0], mosi_i};
        p_nxt.miso_sy = {p_r.miso_sy[0], miso_i};
        p_nxt.sel_sy  = {p_r.sel_sy[0], sel_n_i};
        p_nxt.ack     = wb_req;
        sh.load       = 1'b0;
        sh.tx_byte    = wb_dat_i[7:0];
        // software clears first, hardware sets after so set wins
        if (wb_req && wb_we_i && wb_sel_i[0]) begin
            if (hit(wb_adr_i, STATUS_IDX)) begin
                p_nxt.done     = p_r.done     & ~wb_dat_i[DONE_BIT];
                p_nxt.clash    = p_r.clash    & ~wb_dat_i[CLASH_BIT];
                p_nxt.overrun  = p_r.overrun  & ~wb_dat_i[OVERRUN_BIT];
                p_nxt.conflict = p_r.conflict & ~wb_dat_i[CONFLICT_BIT];
                p_nxt.det_off  = wb_dat_i[DETOFF_BIT];
            end else if (hit(wb_adr_i, DATA_IDX)) begin
                if (p_r.done || sh.busy) begin
                    p_nxt.clash = 1'b1;
                end else begin
                    sh.load       = 1'b1;
                    p_nxt.tx_full = 1'b1;
                end
            end else if (hit(wb_adr_i, CONTROL_IDX)) begin
                p_nxt.ctrl = wb_dat_i[7:0];
            end else if (hit(wb_adr_i, MASK_IDX)) begin
                p_nxt.mask = wb_dat_i[7:0];
            end
        end
        // buffer empties once shifting begins or ends
        if (sh.done || (p_r.tx_full && sh.busy)) begin
            p_nxt.tx_full = 1'b0;
        end
        if (sh.done) begin
            if (p_r.done) begin
                p_nxt.overrun = 1'b1;
            end else begin
                p_nxt.rbuf = sh.rx_byte;
            end
            p_nxt.done = 1'b1;
        end
        if (detect_on && sel_low) begin
            p_nxt.conflict = 1'b1;
            p_nxt.ctrl[ROLE_BIT] = 1'b0;
        end
        p_nxt.rdat = 8'h_0000;
        if (hit(wb_adr_i, STATUS_IDX)) begin
            p_nxt.rdat = {p_r.done, p_r.clash, p_r.overrun, p_r.conflict,
                          p_r.det_off, p_r.tx_full, 2'b00};
        end else if (hit(wb_adr_i, DATA_IDX)) begin
            p_nxt.rdat = p_r.rbuf;
        end else if (hit(wb_adr_i, CONTROL_IDX)) begin
            p_nxt.rdat = p_r.ctrl;
        end else if (hit(wb_adr_i, MASK_IDX)) begin
            p_nxt.rdat = p_r.mask;
        end else if (hit(wb_adr_i, EVENT_IDX)) begin
            p_nxt.rdat = events & p_r.mask;
        end
        if (!ce) begin
            p_nxt = p_r;
            sh.load = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            p_r <= '{2'b00, 2'b00, 2'b00, 2'b11, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                     DATA_RST, CONTROL_RST, MASK_RST, 1'b0, 8'h_0000};
        end else begin
            p_r <= p_nxt;
        end
    end

    // =========================================================
    // shifter
    spi_shifter u_shift (
        .clk       (clk),
        .reset     (reset),
        .ce        (ce),
        .is_master (master),
        .sck_s     (p_r.sck_sy[1]),
        .sel_s_n   (p_r.sel_sy[1]),
        .din_s     (master ? p_r.miso_sy[1] : p_r.mosi_sy[1]),
        .sck_out   (sck_o),
        .dout      (mosi_o),
        .sh        (sh.core)
    );

    // =========================================================
    // pins
    assign sck_oe_n  = !master;
    assign mosi_oe_n = !master;
    assign miso_o    = mosi_o;
    assign miso_oe_n = master || p_r.sel_sy[1];
    assign sel_n_o   = !sh.busy;
    assign sel_oe_n  = !(master && p_r.det_off && p_r.ctrl[SELOE_BIT]);

    // =========================================================
    // bus answer and interrupt
    assign wb_ack_o = p_r.ack;
    assign wb_dat_o = {24'h_0000_00, p_r.rdat};
    assign irq = p_r.ctrl[IRQEN_BIT] && p_r.ctrl[GIRQEN_BIT] && (|(events & p_r.mask));
endmodule

// ### spi_port_monitor.sv
// Purpose: port-level checks on the serial status and data port
// Assumes: ce held high by the bench
// Notes:   sees only top-level ports
`timescale 1ns/100ps
module spi_port_monitor
    import spi_pkg::*;
(
    // system
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        ce,
    // wishbone
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // link pins
    input wire logic        sck_o,
    input wire logic        sck_oe_n,
    input wire logic        mosi_oe_n,
    input wire logic        miso_oe_n,
    input wire logic        sel_n_o,
    input wire logic        sel_oe_n
);
    // =========================================================
    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_next_cycle: assert property (ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("ack without request");
    a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_sck_in_frame: assert property (!sck_oe_n && $rose(sck_o) |-> !sel_n_o)
        else $error("link clock outside select frame");
    a_sck_half_period: assert property ($rose(sck_o) |-> sck_o [*4] ##1 !sck_o)
        else $error("link clock high time wrong");
    a_sel_master_only: assert property (!sel_oe_n |-> !sck_oe_n)
        else $error("select driven outside master mode");
    a_role_pins_pair: assert property (mosi_oe_n == sck_oe_n)
        else $error("clock and data drive disagree");
    a_miso_slave_only: assert property (!miso_oe_n |-> sck_oe_n)
        else $error("miso driven in master mode");
endmodule
bind spi_port spi_port_monitor mon (.clk(clk), .reset(reset), .ce(ce), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sck_o(sck_o),
    .sck_oe_n(sck_oe_n), .mosi_oe_n(mosi_oe_n), .miso_oe_n(miso_oe_n), .sel_n_o(sel_n_o),
    .sel_oe_n(sel_oe_n));

// ### spi_dev_model.sv
// Purpose: external serial slave device on the link
// Assumes: mode 0, msb first
// Notes:   released miso shows the inverse of its last bit
`timescale 1ns/100ps
module spi_dev_model (
    // link
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    output logic            miso,
    // bench side
    input  wire logic [7:0] reply,
    output logic      [7:0] rx
);
    logic [7:0] sh;
    initial begin
        sh = 8'h00;
        rx = 8'h00;
    end
    always @(negedge sel_n) sh = reply;
    always @(posedge sck) if (!sel_n) rx = {rx[6:0], mosi};
    always @(negedge sck) if (!sel_n) sh = {sh[6:0], 1'b0};
    assign miso = sel_n ? ~sh[7] : sh[7];
endmodule

// ### tb_top.sv
// Purpose: self-checking bench for the serial status and data port
// Assumes: wishbone at word addresses, link clock 320 ns as master, 360 ns as driven slave
// Notes:   random bytes from a fixed seed
`timescale 1ns/100ps
module tb_top;
    import spi_pkg::*;
    logic        clk, reset, cyc, stb, we, sck_d, mosi_d, sel_d;
    logic [31:0] adr, dat, wb_dat_o;
    logic        wb_ack_o, sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
    logic        sel_n_o, sel_oe_n, irq, dev_miso;
    logic [7:0]  reply, dev_rx, q, tx, b1, b2;
    int          fails, check_count, n;
    wire sck_w  = sck_oe_n ? sck_d : sck_o;
    wire mosi_w = mosi_oe_n ? mosi_d : mosi_o;
    wire miso_w = miso_oe_n ? dev_miso : miso_o;
    wire sel_w  = sel_oe_n ? sel_d : sel_n_o;
    spi_port uut (.clk(clk), .reset(reset), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .sck_i(sck_w), .sck_o(sck_o), .sck_oe_n(sck_oe_n),
        .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_n(mosi_oe_n), .miso_i(miso_w),
        .miso_o(miso_o), .miso_oe_n(miso_oe_n), .sel_n_i(sel_w), .sel_n_o(sel_n_o),
        .sel_oe_n(sel_oe_n), .irq(irq));
    spi_dev_model dev (.sck(sck_w), .mosi(mosi_w), .sel_n(sel_w), .miso(dev_miso),
        .reply(reply), .rx(dev_rx));
    // =========================================================
    // helpers
    function automatic logic [31:0] ad(input logic [7:0] i);
        ad = {22'h0, i, 2'b00};
    endfunction
    function automatic logic [7:0] fl(input logic dn, cl, ov, cf, dt);
        fl = 8'h00;
        fl[DONE_BIT] = dn;
        fl[CLASH_BIT] = cl;
        fl[OVERRUN_BIT] = ov;
        fl[CONFLICT_BIT] = cf;
        fl[DETOFF_BIT] = dt;
    endfunction
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wb(input logic w, input logic [31:0] a, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h0, d};
        n = 0;
        do begin @(posedge clk); n++; end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o[7:0];
        if (n >= 20) fails++;
        cyc <= 1'b0; stb <= 1'b0;
    endtask
    task automatic xfer(input logic [7:0] t, input logic [7:0] r);
        reply = r;
        wb(1'b1, ad(DATA_IDX), t);
        for (int i = 0; i < 40; i++) begin
            wb(1'b0, ad(STATUS_IDX), 8'h00);
            if (q[DONE_BIT] === 1'b1) break;
        end
    endtask
    task automatic sbyte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk); mosi_d <= b[i];
            repeat (4) @(posedge clk); sck_d <= 1'b1;
            repeat (4) @(posedge clk); sck_d <= 1'b0;
        end
        repeat (8) @(posedge clk);
    endtask
    task automatic irqchk(input logic e);
        repeat (2) @(negedge clk);
        chk8({7'h0, irq}, {7'h0, e});
    endtask
    task end_sim;
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // =========================================================
    // clock, watchdog, tests
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #400000;
        fails++;
        end_sim;
    end
    initial begin
        reset = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 0; dat = 0;
        sck_d = 1'b0; mosi_d = 1'b0; sel_d = 1'b1; reply = 8'h00; q = 8'h00;
        fails = 0; check_count = 0;
        void'($urandom(32'hd2b238ff));
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        wb(1'b0, ad(STATUS_IDX), 8'h00); chk8(q, STATUS_RST);
        wb(1'b0, ad(DATA_IDX), 8'h00); chk8(q, DATA_RST);
        wb(1'b0, 32'h0000_0100, 8'h00); chk8(q, 8'h00);
        wb(1'b1, ad(CONTROL_IDX), 8'h03);
        wb(1'b1, ad(STATUS_IDX), fl(0, 0, 0, 0, 1));
        @(negedge clk); chk8({7'h0, sel_oe_n}, 8'h00);
        for (int k = 0; k < 3; k++) begin
            tx = (k == 0) ? 8'h00 : 8'($urandom);
            b1 = (k == 0) ? 8'hff : 8'($urandom);
            xfer(tx, b1);
            chk8(q, fl(1, 0, 0, 0, 1));
            chk8(dev_rx, tx);
            wb(1'b1, ad(DATA_IDX), ~tx);
            wb(1'b0, ad(STATUS_IDX), 8'h00); chk8(q, fl(1, 1, 0, 0, 1));
            wb(1'b0, ad(DATA_IDX), 8'h00); chk8(q, b1);
            wb(1'b1, ad(STATUS_IDX), fl(1, 1, 0, 0, 1));
            wb(1'b0, ad(STATUS_IDX), 8'h00); chk8(q, fl(0, 0, 0, 0, 1));
        end
        wb(1'b1, ad(CONTROL_IDX), 8'h00);
        wb(1'b1, ad(STATUS_IDX), 8'h00);
        wb(1'b1, ad(DATA_IDX), 8'h5a);
        wb(1'b0, ad(STATUS_IDX), 8'h00); chk8(q, 8'(1 << TXFULL_BIT));
        b1 = 8'($urandom); b2 = 8'($urandom);
        sel_d <= 1'b0;
        sbyte(b1);
        sbyte(b2);
        sel_d <= 1'b1;
        wb(1'b0, ad(STATUS_IDX), 8'h00); chk8(q, fl(1, 0, 1, 0, 0));
        wb(1'b0, ad(DATA_IDX), 8'h00); chk8(q, b1);
        wb(1'b1, ad(STATUS_IDX), fl(1, 0, 1, 0, 0));
        wb(1'b0, ad(STATUS_IDX), 8'h00); chk8(q, 8'h00);
        wb(1'b1, ad(MASK_IDX), fl(0, 0, 0, 1, 0));
        wb(1'b1, ad(CONTROL_IDX), 8'h0f);
        wb(1'b1, ad(STATUS_IDX), 8'h00);
        @(negedge clk); chk8({7'h0, sel_oe_n}, 8'h01);
        sel_d <= 1'b0;
        repeat (4) @(posedge clk);
        sel_d <= 1'b1;
        wb(1'b0, ad(STATUS_IDX), 8'h00); chk8(q, fl(0, 0, 0, 1, 0));
        irqchk(1'b1);
        wb(1'b0, ad(EVENT_IDX), 8'h00); chk8(q, fl(0, 0, 0, 1, 0));
        wb(1'b0, ad(CONTROL_IDX), 8'h00); chk8(q, 8'h0e);
        wb(1'b1, ad(MASK_IDX), 8'h00); irqchk(1'b0);
        wb(1'b1, ad(MASK_IDX), fl(0, 0, 0, 1, 0)); irqchk(1'b1);
        wb(1'b1, ad(STATUS_IDX), fl(0, 0, 0, 1, 0)); irqchk(1'b0);
        end_sim;
    end
endmodule
